// File: erb_top.sv
// Purpose: Embedded block RAM with mode, width and pipeline options
// Assumes: All user inputs come from logic on clk_i; config port is a plain strobe port
// Notes:   Port rates differ through per-port clock enables, not separate clocks
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
`include "erb_consts.svh"

module erb_top #(
	parameter  erb_pkg::erb_kind_type KIND = erb_pkg::erb_medium,
	localparam int W   = erb_pkg::erb_word_bits(KIND),
	localparam int D   = erb_pkg::erb_depth(KIND),
	localparam int AWW = $clog2(D),
	localparam int DB  = W / `ERB_LANE * `ERB_BYTE,
	localparam int LDB = $clog2(DB),
	localparam int AW  = AWW + LDB
) (
	input  wire logic            clk_i,
	input  wire logic            rst_n_i,
	input  wire logic [3:0]      cfg_addr_i,
	input  wire logic [31:0]     cfg_wdata_i,
	input  wire logic            cfg_wr_i,
	input  wire logic            cfg_rd_i,
	output logic      [31:0]     cfg_rdata_o,
	input  wire logic            clr_i,
	input  wire logic            ce_a_i,
	input  wire logic            en_a_i,
	input  wire logic            we_a_i,
	input  wire logic [AW-1:0]   addr_a_i,
	input  wire logic [W-1:0]    d_a_i,
	output logic      [W-1:0]    q_a_o,
	input  wire logic            ce_b_i,
	input  wire logic            en_b_i,
	input  wire logic            we_b_i,
	input  wire logic [AW-1:0]   addr_b_i,
	input  wire logic [W-1:0]    d_b_i,
	output logic      [W-1:0]    q_b_o,
	input  wire logic            pre_we_i,
	input  wire logic [AWW-1:0]  pre_addr_i,
	input  wire logic [W-1:0]    pre_d_i
);

	localparam logic [W-1:0] ONES = {W{1'b1}};

	////////////////////////////////////////////////////////////////////////////////
	// Lane mapping between data-only view and physical word with parity bits

	function automatic logic [W-1:0] expand(input logic [DB-1:0] v);
		logic [W-1:0] r;
		r = '0;
		for (int i = 0; i < DB; i++) begin
			r[i + i / `ERB_BYTE] = v[i];
		end
		return r;
	endfunction : expand

	function automatic logic [DB-1:0] collapse(input logic [W-1:0] v);
		logic [DB-1:0] r;
		r = '0;
		for (int i = 0; i < DB; i++) begin
			r[i] = v[i + i / `ERB_BYTE];
		end
		return r;
	endfunction : collapse

	// Element width: parity codes give nine-bit multiples
	function automatic int ew_of(input logic [2:0] c, input logic par);
		return par ? (`ERB_LANE << (c - `ERB_PAR_CODE)) : (1 << c);
	endfunction : ew_of

	function automatic logic [AWW-1:0] widx_of(input logic [AW-1:0] a, input logic [2:0] c);
		return AWW'(a >> (LDB - int'(c)));
	endfunction : widx_of

	function automatic logic [7:0] off_of(input logic [AW-1:0] a, input logic [2:0] c, input int ew);
		int sel;
		sel = int'(a) & ((1 << (LDB - int'(c))) - 1);
		return 8'(sel * ew);
	endfunction : off_of

	////////////////////////////////////////////////////////////////////////////////
	// Configuration registers

	logic [31:0] ctrl, next_ctrl, width, next_width, next_rdata;
	logic        coll, next_coll, coll_ev;
	erb_pkg::erb_mode_type mode_raw, mode;

	always_comb begin
		next_ctrl  = ctrl;
		next_width = width;
		next_coll  = coll;
		next_rdata = 32'h0000_0000;
		if (cfg_wr_i && cfg_addr_i == `ERB_CTRL_OFS) begin
			next_ctrl = cfg_wdata_i;
			next_ctrl[`ERB_CTRL_LOCK] = cfg_wdata_i[`ERB_CTRL_LOCK] | ctrl[`ERB_CTRL_LOCK];
		end
		if (cfg_wr_i && cfg_addr_i == `ERB_WIDTH_OFS) begin
			next_width = cfg_wdata_i;
		end
		if (cfg_wr_i && cfg_addr_i == `ERB_STATUS_OFS && cfg_wdata_i[`ERB_ST_COLL]) begin
			next_coll = 1'b0;
		end
		// Event in the clearing cycle still lands
		if (coll_ev) begin
			next_coll = 1'b1;
		end
		if (cfg_rd_i) begin
			case (cfg_addr_i)
				`ERB_CTRL_OFS:   next_rdata = ctrl;
				`ERB_WIDTH_OFS:  next_rdata = width;
				`ERB_STATUS_OFS: begin
					next_rdata[`ERB_ST_COLL] = coll;
					next_rdata[`ERB_ST_LOCK] = ctrl[`ERB_CTRL_LOCK];
					next_rdata[`ERB_ST_KIND +: 2] = KIND;
				end
				default:         next_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ctrl        <= `ERB_CTRL_RST;
			width       <= `ERB_WIDTH_RST;
			coll        <= 1'b0;
			cfg_rdata_o <= 32'h0000_0000;
		end else begin
			ctrl        <= next_ctrl;
			width       <= next_width;
			coll        <= next_coll;
			cfg_rdata_o <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Mode decode; unsupported requests fall back to the nearest legal mode

	logic       rdw_old, flow, pre_ok;
	logic [1:0] oreg, rd_ok, we_ok, on;
	logic [1:0][2:0] cw;
	logic [1:0]      cp;

	assign mode_raw = erb_pkg::erb_mode_type'(ctrl[`ERB_CTRL_MODE +: 2]);

	always_comb begin
		mode = mode_raw;
		if (mode_raw == erb_pkg::erb_true_dual && KIND == erb_pkg::erb_small) begin
			mode = erb_pkg::erb_simple_dual;
		end
		if (mode_raw == erb_pkg::erb_split_single && KIND != erb_pkg::erb_medium) begin
			mode = erb_pkg::erb_single;
		end
	end

	assign flow    = ctrl[`ERB_CTRL_FLOW] && mode == erb_pkg::erb_simple_dual
	                 && KIND != erb_pkg::erb_large;
	assign oreg[0] = ctrl[`ERB_CTRL_OREG_A];
	assign oreg[1] = ctrl[`ERB_CTRL_OREG_B] && !flow;
	assign rdw_old = ctrl[`ERB_CTRL_RDW_OLD] && KIND != erb_pkg::erb_large;
	assign pre_ok  = pre_we_i && !ctrl[`ERB_CTRL_LOCK] && KIND != erb_pkg::erb_large;
	assign rd_ok   = {mode != erb_pkg::erb_single, mode != erb_pkg::erb_simple_dual};
	assign we_ok   = {mode == erb_pkg::erb_true_dual || mode == erb_pkg::erb_split_single, 1'b1};
	assign on      = {mode != erb_pkg::erb_single, 1'b1};
	// Per-port widths over one array
	assign cw[0]   = width[2:0];
	assign cw[1]   = width[`ERB_WID_B +: 3];
	assign cp[0]   = width[`ERB_WID_PAR] && width[2:0] >= `ERB_PAR_CODE;
	assign cp[1]   = width[`ERB_WID_B + `ERB_WID_PAR] && cw[1] >= `ERB_PAR_CODE;

	////////////////////////////////////////////////////////////////////////////////
	// Input registers; preload shares port A's path

	logic [1:0]          ce, en, we, go, s_we, next_go, next_we;
	logic [1:0][AW-1:0]  ad, s_ad, next_ad;
	logic [1:0][W-1:0]   di, s_d, next_d;
	logic                s_pre, next_pre, fl_go, fl_nx_go;
	logic [AW-1:0]       fl_ad, fl_nx_ad;

	assign ce = {ce_b_i, ce_a_i};
	assign en = {en_b_i, en_a_i};
	assign we = {we_b_i, we_a_i};
	assign ad = {addr_b_i, addr_a_i};
	assign di = {d_b_i, d_a_i};

	always_comb begin
		next_pre = 1'b0;
		for (int p = 0; p < 2; p++) begin
			next_go[p] = 1'b0;
			next_we[p] = s_we[p];
			next_ad[p] = s_ad[p];
			next_d[p]  = s_d[p];
			if (ce[p] && en[p] && on[p]) begin
				next_go[p] = 1'b1;
				next_we[p] = we[p] && we_ok[p];
				next_ad[p] = ad[p];
				next_d[p]  = di[p];
			end
		end
		if (pre_ok) begin
			next_pre   = 1'b1;
			next_go[0] = 1'b1;
			next_we[0] = 1'b1;
			next_ad[0] = {pre_addr_i, {LDB{1'b0}}};
			next_d[0]  = pre_d_i;
		end
		if (clr_i && KIND != erb_pkg::erb_large) begin
			next_pre = 1'b0;
			next_go  = '0;
			next_we  = '0;
			next_ad  = '0;
			next_d   = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			go    <= '0;
			s_we  <= '0;
			s_ad  <= '0;
			s_d   <= '0;
			s_pre <= 1'b0;
		end else begin
			go    <= next_go;
			s_we  <= next_we;
			s_ad  <= next_ad;
			s_d   <= next_d;
			s_pre <= next_pre;
		end
	end

	// Flow-through read inputs, taken half a cycle early
	always_comb begin
		fl_nx_go = en_b_i && flow;
		fl_nx_ad = addr_b_i;
		if (clr_i && KIND != erb_pkg::erb_large) begin
			fl_nx_go = 1'b0;
		end
	end

	always_ff @(negedge clk_i) begin
		if (!rst_n_i) begin
			fl_go <= 1'b0;
			fl_ad <= '0;
		end else begin
			fl_go <= fl_nx_go;
			fl_ad <= fl_nx_ad;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Array access: internal strobe is the one-cycle capture flag

	logic [1:0]          mwe, mre, pgo;
	logic [1:0][AWW-1:0] widx;
	logic [1:0][W-1:0]   wd, wm, mq;
	logic [1:0][7:0]     off;

	always_comb begin
		int ew;
		logic [W-1:0]  em, tv;
		logic [AW-1:0] a;
		ew = 0;
		em = '0;
		tv = '0;
		a  = '0;
		for (int p = 0; p < 2; p++) begin
			a      = (p == 1 && flow) ? fl_ad : s_ad[p];
			pgo[p] = (p == 1 && flow) ? fl_go : go[p];
			ew     = ew_of(cw[p], cp[p]);
			em     = ONES >> (W - ew);
			off[p] = off_of(a, cw[p], ew);
			widx[p] = widx_of(a, cw[p]);
			if (mode == erb_pkg::erb_split_single) begin
				widx[p][AWW-1] = 1'(p);
			end
			if (cp[p]) begin
				wm[p] = em << off[p];
				wd[p] = (s_d[p] & em) << off[p];
			end else begin
				tv    = em << off[p];
				wm[p] = expand(tv[DB-1:0]);
				tv    = (s_d[p] & em) << off[p];
				wd[p] = expand(tv[DB-1:0]);
			end
			mwe[p] = pgo[p] && s_we[p] && !(p == 1 && flow);
			mre[p] = pgo[p] && rd_ok[p];
		end
		if (s_pre) begin
			widx[0] = s_ad[0][AW-1 -: AWW];
			wm[0]   = ONES;
			wd[0]   = s_d[0];
			mre[0]  = 1'b0;
		end
	end

	// Cross-port hit on one word while one side writes
	assign coll_ev = pgo[0] && pgo[1] && widx[0] == widx[1]
	                 && ((mwe[0] && mre[1] && !mwe[1]) || (mwe[1] && mre[0] && !mwe[0]));

	erb_mem #(.W(W), .D(D)) u_mem (
		.clk_i  (clk_i),
		.we_i   (mwe),
		.re_i   (mre),
		.addr_i (widx),
		.d_i    (wd),
		.m_i    (wm),
		.q_o    (mq)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Read path: element select, optional output register, clear

	logic [1:0]        r_go, r_par, r_und, hold, next_rgo, next_rpar, next_rund, next_hold;
	logic [1:0][2:0]   r_c, next_rc;
	logic [1:0][7:0]   r_off, next_roff;
	logic [1:0][W-1:0] elem, q_reg, next_q, q_out;

	always_comb begin
		logic [W-1:0] view;
		view = '0;
		for (int p = 0; p < 2; p++) begin
			view   = r_par[p] ? mq[p] : W'(collapse(mq[p]));
			elem[p] = (view >> r_off[p]) & (ONES >> (W - ew_of(r_c[p], r_par[p])));
			if (r_und[p]) begin
				elem[p] = {W{`ERB_RDW_FILL}};
			end
			next_rgo[p]  = mre[p];
			next_rc[p]   = mre[p] ? cw[p] : r_c[p];
			next_rpar[p] = mre[p] ? cp[p] : r_par[p];
			next_roff[p] = mre[p] ? off[p] : r_off[p];
			next_rund[p] = mre[p] ? (coll_ev && !rdw_old && !mwe[p]) : r_und[p];
			next_q[p]    = r_go[p] ? elem[p] : q_reg[p];
			// Released with the array read, else the first result after clear shows 0
			next_hold[p] = mre[p] ? 1'b0 : hold[p];
			if (clr_i) begin
				next_q[p]    = '0;
				next_hold[p] = 1'b1;
			end
			q_out[p] = oreg[p] ? q_reg[p] : (hold[p] ? '0 : elem[p]);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			r_go  <= '0;
			r_c   <= '0;
			r_par <= '0;
			r_off <= '0;
			r_und <= '0;
			q_reg <= '0;
			hold  <= '1;
		end else begin
			r_go  <= next_rgo;
			r_c   <= next_rc;
			r_par <= next_rpar;
			r_off <= next_roff;
			r_und <= next_rund;
			q_reg <= next_q;
			hold  <= next_hold;
		end
	end

	assign q_a_o = q_out[0];
	assign q_b_o = q_out[1];

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_a_write;
		mwe[0] && mre[0] && wm[0] == ONES;
	endsequence

	a_dual_b_write: assert property (
		(mode == erb_pkg::erb_true_dual && go[1] && s_we[1]) |-> mwe[1] && mre[1])
		else $error("true dual port B write not issued");
	a_rdw_unknown: assert property (
		(coll_ev && !rdw_old && mre[1] && !mwe[1]) |=> q_b_o == ONES || oreg[1] || hold[1])
		else $error("mixed-port read not marked unknown");
	a_single_through: assert property (
		(s_a_write and ##0 !oreg[0] && !clr_i && !s_pre) |=> q_a_o == $past(wd[0]))
		else $error("single-port write data not on q");
	a_input_capture: assert property (
		(ce_a_i && en_a_i && !pre_ok && !clr_i) |=> go[0] && s_ad[0] == $past(addr_a_i))
		else $error("port A inputs not registered");
	a_strobe_pulse: assert property (
		(!(ce_a_i && en_a_i) && !pre_ok) |=> !mwe[0] && !go[0])
		else $error("write strobe without capture");
	a_oreg_delay: assert property (
		(r_go[0] && oreg[0] && !clr_i) ##1 oreg[0] |-> q_a_o == $past(elem[0]))
		else $error("output register lost read data");
	a_flow_read: assert property (
		(flow && fl_go && !clr_i) |=> r_go[1] ##0 !oreg[1])
		else $error("flow-through read not one edge");
	a_split_half: assert property (
		(mode == erb_pkg::erb_split_single && pgo[1]) |-> widx[1][AWW-1] && !widx[0][AWW-1])
		else $error("split halves overlap");
	a_large_no_pre: assert property (
		(KIND == erb_pkg::erb_large) |-> !pre_ok ##1 !s_pre)
		else $error("large block took preload");
	a_clear_regs: assert property (
		clr_i |=> q_reg == '0 && (KIND == erb_pkg::erb_large || go == '0))
		else $error("clear left registers set");

endmodule : erb_top

// File: erb_consts.svh
// Purpose: Constants for the embedded block RAM: offsets, fields, resets, sizes
// Assumes: Included by bare name from the package and the design files
// Notes:   Block geometry per kind is given as physical word width and depth
//
// Function
// - Medium and large blocks offer true dual-port: two reads, two writes or one of each, ports at own rates.
// - Simple dual-port takes a read and a write together; a read of the written word gives old data or unknown bits.
// - Single-port never reads and writes together; written data shows on q at once, or one edge later if registered.
// - Every block input is captured in a register, so writes are synchronous and reads can be pipelined.
// - The write strobe into the array is made inside the block from its clock, not by the user.
// - The output data registers can be bypassed so array data leaves unregistered.
// - Small and medium blocks in simple dual-port can read flow-through: read inputs taken on the falling edge, no out reg.
// - The two ports of a dual-port setup may use different data widths over the same storage.
// - A medium block can hold two independent single-port memories, each at most half the block.
// - The large block cannot be preloaded; only small and medium blocks take initial contents.
// - Clear resets input and output registers on small and medium blocks, only output registers on the large block.
`ifndef ERB_CONSTS_SVH
`define ERB_CONSTS_SVH

`define ERB_CTRL_OFS     4'h0
`define ERB_WIDTH_OFS    4'h4
`define ERB_STATUS_OFS   4'h8

`define ERB_CTRL_MODE    0
`define ERB_CTRL_RDW_OLD 2
`define ERB_CTRL_OREG_A  3
`define ERB_CTRL_OREG_B  4
`define ERB_CTRL_FLOW    5
`define ERB_CTRL_LOCK    6
`define ERB_WID_B        4
`define ERB_WID_PAR      3
`define ERB_ST_COLL      0
`define ERB_ST_LOCK      1
`define ERB_ST_KIND      2

`define ERB_CTRL_RST     32'h0000_0019
`define ERB_WIDTH_RST    32'h0000_0000
`define ERB_RDW_FILL     1'b1

`define ERB_LANE         9
`define ERB_BYTE         8
`define ERB_PAR_CODE     3
`define ERB_SMALL_W      18
`define ERB_SMALL_D      32
`define ERB_MEDIUM_W     36
`define ERB_MEDIUM_D     128
`define ERB_LARGE_W      144
`define ERB_LARGE_D      4096

`endif

// File: erb_pkg.sv
// Purpose: Types and geometry functions for the embedded block RAM
// Assumes: Constants header available on the include path
// Notes:   Enums carry no codes; order matters for the mode field
`include "erb_consts.svh"

package erb_pkg;

	typedef enum logic [1:0] {erb_small, erb_medium, erb_large} erb_kind_type;

	typedef enum logic [1:0] {erb_single, erb_simple_dual, erb_true_dual, erb_split_single} erb_mode_type;

	// Fixed capacity per kind, parity lanes included
	function automatic int erb_word_bits(input erb_kind_type k);
		case (k)
			erb_small:  return `ERB_SMALL_W;
			erb_medium: return `ERB_MEDIUM_W;
			default:    return `ERB_LARGE_W;
		endcase
	endfunction : erb_word_bits

	function automatic int erb_depth(input erb_kind_type k);
		case (k)
			erb_small:  return `ERB_SMALL_D;
			erb_medium: return `ERB_MEDIUM_D;
			default:    return `ERB_LARGE_D;
		endcase
	endfunction : erb_depth

endpackage : erb_pkg

// File: erb_mem.sv
// Purpose: Two-port storage array with bit write mask and registered read data
// Assumes: Both ports on one clock; strobes are one cycle long
// Notes:   Own-port read of a written word returns new data; other port sees old
`timescale 1ns/1ns

module erb_mem #(
	parameter  int W   = 36,
	parameter  int D   = 128,
	localparam int AWW = $clog2(D)
) (
	input  wire logic                    clk_i,
	input  wire logic [1:0]              we_i,
	input  wire logic [1:0]              re_i,
	input  wire logic [1:0][AWW-1:0]     addr_i,
	input  wire logic [1:0][W-1:0]       d_i,
	input  wire logic [1:0][W-1:0]       m_i,
	output logic      [1:0][W-1:0]       q_o
);

	logic [W-1:0] store [D];

	////////////////////////////////////////////////////////////////////////////////
	// Port B write lands last, so it wins a same-word double write
	always_ff @(posedge clk_i) begin
		for (int p = 0; p < 2; p++) begin
			if (we_i[p]) begin
				store[addr_i[p]] <= (store[addr_i[p]] & ~m_i[p]) | (d_i[p] & m_i[p]);
			end
			if (re_i[p]) begin
				if (we_i[p]) begin
					q_o[p] <= (store[addr_i[p]] & ~m_i[p]) | (d_i[p] & m_i[p]);
				end else begin
					q_o[p] <= store[addr_i[p]];
				end
			end
		end
	end

endmodule : erb_mem

// File: erb_user_model.sv
// Purpose: Fabric-side user logic that issues port A and B requests to the block RAM
// Assumes: Requests are queued by the bench and launched one rising edge later
// Notes:   Idle address and data invert every cycle so stale values never look valid
`timescale 1ns/1ns

module erb_user_model #(
	parameter int AW = 12,
	parameter int W  = 36
) (
	input  wire logic          clk_i,
	output logic               ce_a_o,
	output logic               en_a_o,
	output logic               we_a_o,
	output logic [AW-1:0]      addr_a_o,
	output logic [W-1:0]       d_a_o,
	output logic               ce_b_o,
	output logic               en_b_o,
	output logic               we_b_o,
	output logic [AW-1:0]      addr_b_o,
	output logic [W-1:0]       d_b_o
);
	typedef struct {int when; logic we; logic [AW-1:0] a; logic [W-1:0] d;} erb_um_req_type;
	erb_um_req_type  rq [2][$];
	int              cnt = 0;
	logic [1:0]      en  = 2'h0;
	logic [1:0]      we  = 2'h0;
	logic [AW-1:0]   ad [2] = '{'0, '0};
	logic [W-1:0]    dd [2] = '{'0, '0};

	////////////////////////////////////////////////////////////////
	task automatic req(input int p, input logic w, input logic [AW-1:0] a, input logic [W-1:0] d);
		rq[p].push_back('{cnt + 1, w, a, d});
	endtask : req

	// Write enable is a plain level beside address and data, no pulse shaping
	// Idle cycles hold both write enables low
	always @(posedge clk_i) begin
		for (int p = 0; p < 2; p++) begin
			if (rq[p].size() > 0 && rq[p][0].when == cnt) begin
				en[p] <= 1'b1;
				we[p] <= rq[p][0].we;
				ad[p] <= rq[p][0].a;
				dd[p] <= rq[p][0].d;
				void'(rq[p].pop_front());
			end else begin
				en[p] <= 1'b0;
				we[p] <= 1'b0;
				ad[p] <= ~ad[p];
				dd[p] <= ~dd[p];
			end
		end
		cnt <= cnt + 1;
	end

	assign ce_a_o   = 1'b1;
	assign ce_b_o   = 1'b1;
	assign en_a_o   = en[0];
	assign we_a_o   = we[0];
	assign addr_a_o = ad[0];
	assign d_a_o    = dd[0];
	assign en_b_o   = en[1];
	assign we_b_o   = we[1];
	assign addr_b_o = ad[1];
	assign d_b_o    = dd[1];
endmodule : erb_user_model

// File: testbench.sv
// Purpose: Self-checking bench for the medium block RAM in every mode
// Assumes: Expected results are queued with their due cycle and checked at the falling edge
// Notes:   Config writes first wait four cycles so reads in flight finish under the old setup
`timescale 1ns/1ns
`define ERB_CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("wrong value at %0t: got %h expected %h", $time, got, exp); end end

module testbench;
	localparam int W = 36;
	localparam int AW = 12;
	typedef struct {int due; int port; logic [W-1:0] val;} erb_tb_note_type;
	logic clk_i = 0, rst_n_i = 0, cfg_wr_i = 0, cfg_rd_i = 0, clr_i = 0, pre_we_i = 0;
	logic [3:0] cfg_addr_i = 4'h0;
	logic [31:0] cfg_wdata_i = 32'h0, cfg_rdata_o;
	logic ce_a_i, en_a_i, we_a_i, ce_b_i, en_b_i, we_b_i;
	logic [AW-1:0] addr_a_i, addr_b_i;
	logic [W-1:0] d_a_i, d_b_i, q_a_o, q_b_o, v, x, y, pre_d_i = '0;
	logic [6:0] pre_addr_i = 7'h0;
	logic [W-1:0] ref_mem [128];
	logic [8:0] e [4];
	erb_tb_note_type notes [$];
	int seed, cyc = 0, n_mismatch = 0, total_checks = 0;

	erb_top #(.KIND(erb_pkg::erb_medium)) erb_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_addr_i(cfg_addr_i),
		.cfg_wdata_i(cfg_wdata_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i), .cfg_rdata_o(cfg_rdata_o),
		.clr_i(clr_i), .ce_a_i(ce_a_i), .en_a_i(en_a_i), .we_a_i(we_a_i), .addr_a_i(addr_a_i), .d_a_i(d_a_i),
		.q_a_o(q_a_o), .ce_b_i(ce_b_i), .en_b_i(en_b_i), .we_b_i(we_b_i), .addr_b_i(addr_b_i), .d_b_i(d_b_i),
		.q_b_o(q_b_o), .pre_we_i(pre_we_i), .pre_addr_i(pre_addr_i), .pre_d_i(pre_d_i));
	erb_user_model #(.AW(AW), .W(W)) erb_user_model_i (.clk_i(clk_i), .ce_a_o(ce_a_i), .en_a_o(en_a_i),
		.we_a_o(we_a_i), .addr_a_o(addr_a_i), .d_a_o(d_a_i), .ce_b_o(ce_b_i), .en_b_o(en_b_i),
		.we_b_o(we_b_i), .addr_b_o(addr_b_i), .d_b_o(d_b_i));

	////////////////////////////////////////////////////////////////
	initial begin
		forever #25 clk_i = ~clk_i;
	end

	function automatic logic [W-1:0] rnd();
		return W'({$random(seed), $random(seed)});
	endfunction : rnd

	task automatic note(input int p, input int d, input logic [W-1:0] val);
		notes.push_back('{cyc + d, p, val});
	endtask : note

	task automatic cfg_wr(input logic [3:0] a, input logic [31:0] d);
		repeat (4) @(posedge clk_i);
		cfg_addr_i <= a;
		cfg_wdata_i <= d;
		cfg_wr_i <= 1'b1;
		@(posedge clk_i);
		cfg_wr_i <= 1'b0;
	endtask : cfg_wr

	task automatic cfg_rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clk_i);
		cfg_addr_i <= a;
		cfg_rd_i <= 1'b1;
		note(2, 2, W'(exp));
		@(posedge clk_i);
		cfg_rd_i <= 1'b0;
	endtask : cfg_rd

	// Zero latency means no result is expected on q
	task automatic port(input int p, input logic w, input int a, input logic [W-1:0] d, input int lat,
		input logic [W-1:0] exp);
		erb_user_model_i.req(p, w, AW'(a), d);
		if (lat > 0)
			note(p, 2 + lat, exp);
	endtask : port

	task automatic preload(input int a, input logic [W-1:0] d);
		// Preload takes port A's path: let a request issued just before get captured
		repeat (2) @(posedge clk_i);
		pre_we_i <= 1'b1;
		pre_addr_i <= 7'(a);
		pre_d_i <= d;
		@(posedge clk_i);
		pre_we_i <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask : preload

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up

	////////////////////////////////////////////////////////////////
	// Cycle count doubles as the hang limit
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_mismatch++;
			wrap_up();
		end
	end

	always @(negedge clk_i) begin
		logic [W-1:0] got;
		for (int k = notes.size() - 1; k >= 0; k--) begin
			if (notes[k].due == cyc) begin
				got = notes[k].port == 0 ? q_a_o : notes[k].port == 1 ? q_b_o : W'(cfg_rdata_o);
				`ERB_CHK(got, notes[k].val) // Latency of captured inputs
				notes.delete(k);
			end
		end
	end

	////////////////////////////////////////////////////////////////
	initial begin
		seed = 99;
		repeat (3) @(posedge clk_i);
		rst_n_i <= 1'b1;
		cfg_rd(4'h0, 32'h19);
		cfg_rd(4'h4, 32'h0);
		cfg_rd(4'h8, 32'h4); // Kind field of a fixed-size block
		cfg_rd(4'hc, 32'h0);
		cfg_wr(4'h4, 32'hdd);
		cfg_rd(4'h4, 32'hdd);
		cfg_wr(4'h0, 32'h05);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_i);
			ref_mem[i] = rnd();
			port(0, 1, i, ref_mem[i], 0, '0);
		end
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_i);
			port(1, 0, i, '0, 2, ref_mem[i]); // Read port of simple dual
		end
		@(posedge clk_i);
		v = rnd();
		port(0, 1, 0, v, 0, '0);
		port(1, 0, 0, '0, 2, ref_mem[0]); // Old data on overlap
		ref_mem[0] = v;
		cfg_wr(4'h0, 32'h01);
		@(posedge clk_i);
		v = rnd();
		port(0, 1, 1, v, 0, '0);
		port(1, 0, 1, '0, 2, {W{1'b1}}); // Unknown shown as ones
		ref_mem[1] = v;
		cfg_wr(4'h0, 32'h00);
		@(posedge clk_i);
		v = rnd();
		port(0, 1, 5, v, 2, v); // Write-through, bypassed output
		ref_mem[5] = v;
		cfg_wr(4'h0, 32'h08);
		@(posedge clk_i);
		v = rnd();
		port(0, 1, 6, v, 3, v); // Write-through, registered output
		@(posedge clk_i);
		port(0, 0, 5, '0, 3, ref_mem[5]); // Registered read
		ref_mem[7] = rnd();
		preload(7, ref_mem[7]);
		port(0, 0, 7, '0, 3, ref_mem[7]); // Preloaded contents
		repeat (4) @(posedge clk_i);
		port(0, 1, 7, rnd(), 0, '0);
		note(0, 3, '0); // Output cleared
		@(posedge clk_i);
		clr_i <= 1'b1;
		@(posedge clk_i);
		clr_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		port(0, 0, 7, '0, 3, ref_mem[7]); // Cleared write was dropped
		cfg_wr(4'h0, 32'h48);
		cfg_rd(4'h8, 32'h7); // Sticky mixed-port collision
		cfg_wr(4'h8, 32'h1);
		cfg_rd(4'h8, 32'h6); // Lock flag
		preload(7, rnd());
		port(0, 0, 7, '0, 3, ref_mem[7]); // Locked preload ignored
		// Port B output register on here, so its results come one cycle later
		cfg_wr(4'h0, 32'h12);
		@(posedge clk_i);
		x = rnd();
		y = rnd();
		port(0, 1, 10, x, 2, x); // Two writes at once
		port(1, 1, 11, y, 3, y); // Two writes at once
		@(posedge clk_i);
		port(0, 1, 12, x, 2, x); // Own write data on q
		port(1, 1, 12, y, 3, y); // Own write data on q
		repeat (2) @(posedge clk_i);
		port(0, 0, 11, '0, 2, y); // Two reads at once
		port(1, 0, 10, '0, 3, x); // Two reads at once
		@(posedge clk_i);
		port(0, 0, 12, '0, 2, y); // Port B wins a shared word
		cfg_wr(4'h0, 32'h03);
		@(posedge clk_i);
		x = rnd();
		y = rnd();
		port(0, 1, 3, x, 0, '0);
		port(1, 1, 3, y, 0, '0);
		ref_mem[3] = x;
		repeat (2) @(posedge clk_i);
		port(0, 0, 3, '0, 2, x); // Lower half memory
		port(1, 0, 3, '0, 2, y); // Upper half memory
		cfg_wr(4'h0, 32'h05);
		cfg_wr(4'h4, 32'hdb);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_i);
			e[i] = 9'(rnd());
			port(0, 1, 4 + i, W'(e[i]), 0, '0);
		end
		ref_mem[1] = {e[3], e[2], e[1], e[0]};
		repeat (2) @(posedge clk_i);
		port(1, 0, 1, '0, 2, ref_mem[1]); // Nine-bit writes, full-word read
		cfg_wr(4'h4, 32'h5d);
		port(1, 0, 1, '0, 2, W'({e[3][7:0], e[2][7:0], e[1][7:0], e[0][7:0]})); // Data bits only
		cfg_wr(4'h4, 32'hdd);
		cfg_wr(4'h0, 32'h25);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_i);
			v = W'($random(seed) & 3);
			port(1, 0, int'(v), '0, 1, ref_mem[int'(v)]); // Flow-through read
		end
		repeat (6) @(posedge clk_i);
		`ERB_CHK(notes.size(), 0) // Every expected result was seen
		wrap_up();
	end
endmodule : testbench
